// *** srdm_consts.vh ***
// constants for the receive alignment and protocol monitor
// assumes 16-bit link words, one control flag lane, 32-bit register bus
// ============================================================
// Overview of operation
// - pulse alignment-failure error when the aligner cannot find byte alignment
// - aligner-locked status goes high once aligned to the training pattern
// - seventeen lane lock bits, each high once its lane has locked
// - force-unlock drops all lock and restarts training and alignment
// - one sync status combining alignment lock, channel sync and parity service
// - training-seen debug flag; it does not mean the lanes are deskewed
// - reserved control word flag, informational only, data path unchanged
// - good limit sets consecutive correct parity checks that clear out-of-service
// - bad limit sets consecutive parity mismatches that set out-of-service
// - data keeps flowing while out-of-service is asserted
// - parity error pulses in each cycle with at least one parity mismatch
// - protocol error on an invalid control/data state transition
// - training error when a training sequence is malformed
// - start-of-burst error when data arrives without a payload control word
// - start-of-packet spacing error when two starts come under eight cycles apart
// - overflow error when the staging buffer overflows and data is lost
// - while flush is asserted no data is written downstream
// - flag any burst not closed by an end-of-packet whose length is not a multiple of sixteen bytes
// - flag an end-of-packet abort received on the link
// - on an odd-length burst the pad byte must be zero, else flag
`ifndef SRDM_CONSTS_VH
`define SRDM_CONSTS_VH

// ============================================================
// register word indices
`define SRDM_REG_CTRL 3'h0
`define SRDM_REG_LIMIT 3'h1
`define SRDM_REG_STATUS 3'h2
`define SRDM_REG_LANES 3'h3
`define SRDM_REG_ERR 3'h4

// ============================================================
// field positions
`define SRDM_CTRL_UNLOCK 0
`define SRDM_CTRL_FLUSH 1
`define SRDM_LIMIT_GOOD_LSB 0
`define SRDM_LIMIT_BAD_LSB 4
`define SRDM_LIMIT_RESET 8'h44
`define SRDM_ERR_BITS 11

// ============================================================
// link word encodings
`define SRDM_TRAIN_CW 16'h0fff
`define SRDM_TRAIN_DW 16'hf000
`define SRDM_EOPS_NONE 2'h0
`define SRDM_EOPS_ABORT 2'h1
`define SRDM_EOPS_ONE 2'h3
`define SRDM_SOP_GAP 4'h8
`define SRDM_BURST_WORD_BITS 3

`endif

// *** srdm_sync.v ***
// two-flop synchroniser for a group of link pins
// assumes the pins are stable for many system clocks around each link edge
`timescale 1ns/100ps
module srdm_sync #(
  parameter WIDTH = 18
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // asynchronous pins and their synchronised copy
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;

  // ============================================================
  // first stage feeds only the second
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// *** srdm_top.v ***
// receive alignment, parity service and protocol monitor with register slave
// assumes link pins change away from the link clock rising edge
`timescale 1ns/100ps
`include "srdm_consts.vh"
module srdm_top #(
  parameter LANES = 17,
  parameter LOCK_EDGES = 8,
  parameter ALIGN_EDGES = 64,
  parameter NUM_PORTS = 16
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // link pins
  input wire rdclk_i,
  input wire [15:0] rdat_i,
  input wire rctl_i,
  // register bus
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // forwarded data
  input wire out_ready_i,
  output reg out_valid_o,
  output reg [15:0] out_data_o,
  output reg out_sop_o,
  output reg [7:0] out_port_o,
  // status
  output reg aligner_locked_o,
  output reg [LANES-1:0] lane_locked_o,
  output reg rx_sync_o,
  output reg training_seen_o,
  output reg reserved_ctrl_word_seen_o,
  output reg out_of_service_o,
  // error pulses
  output reg align_fail_err_o,
  output reg parity_err_o,
  output reg protocol_err_o,
  output reg training_err_o,
  output reg sob_err_o,
  output reg sop_spacing_err_o,
  output reg overflow_err_o,
  output reg burst_len_err_o,
  output reg bad_port_addr_err_o,
  output reg eop_abort_o,
  output reg pad_nonzero_err_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_PAY = 3'b010;
  localparam ST_DATA = 3'b100;

  function [3:0] fold4;
    input [15:0] x;
    begin
      fold4 = x[15:12] ^ x[11:8] ^ x[7:4] ^ x[3:0];
    end
  endfunction

  wire [17:0] pins_s;
  reg clk_prev_q;
  reg [1:0] ctrl_q;
  reg [7:0] limit_q;
  reg [`SRDM_ERR_BITS-1:0] err_q;
  reg [2:0] st_q;
  reg [15:0] acc_q;
  reg [15:0] last_q;
  reg [3:0] good_q;
  reg [3:0] bad_q;
  reg [3:0] gap_q;
  reg [`SRDM_BURST_WORD_BITS-1:0] words_q;
  reg data_seen_q;
  reg first_q;
  reg [7:0] lock_cnt_q;
  reg [7:0] align_cnt_q;
  reg deskew_q;
  wire [LANES-1:0] lane_d;
  wire ev;
  wire [15:0] w;
  wire c;
  wire [1:0] eops;
  wire tr_cw;
  wire tr_dw;
  wire all_locked;
  wire [3:0] dip4;
  wire mism;
  wire [`SRDM_ERR_BITS-1:0] err_ev;

  // ============================================================
  // link pin capture and edge find
  srdm_sync #(
    .WIDTH(18)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({rdclk_i, rctl_i, rdat_i}),
    .sync_o(pins_s)
  );

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= pins_s[17];
  end

  assign ev = pins_s[17] & ~clk_prev_q;
  assign w = pins_s[15:0];
  assign c = pins_s[16];
  assign eops = w[14:13];
  assign tr_cw = c & (w == `SRDM_TRAIN_CW);
  assign tr_dw = ~c & (w == `SRDM_TRAIN_DW);
  assign dip4 = fold4(acc_q ^ {w[15:4], 4'hf});
  assign mism = dip4 != w[3:0];
  assign all_locked = &lane_locked_o;

  // ============================================================
  // register slave, one wait cycle per access
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
      ctrl_q <= 2'h0;
      limit_q <= `SRDM_LIMIT_RESET;
    end
    else
    begin
      if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
        avs_waitrequest_o <= 1'b0;
      else
        avs_waitrequest_o <= 1'b1;
      if (avs_read_i & avs_waitrequest_o)
      begin
        case (avs_address_i)
          `SRDM_REG_CTRL: avs_readdata_o <= {30'h0, ctrl_q};
          `SRDM_REG_LIMIT: avs_readdata_o <= {24'h0, limit_q};
          `SRDM_REG_STATUS: avs_readdata_o <= {26'h0, out_of_service_o,
            reserved_ctrl_word_seen_o, training_seen_o, rx_sync_o,
            aligner_locked_o, deskew_q};
          `SRDM_REG_LANES: avs_readdata_o <= {{(32-LANES){1'b0}}, lane_locked_o};
          `SRDM_REG_ERR: avs_readdata_o <= {{(32-`SRDM_ERR_BITS){1'b0}}, err_q};
          default: avs_readdata_o <= 32'h0;
        endcase
      end
      if (avs_write_i & ~avs_waitrequest_o)
      begin
        if (avs_address_i == `SRDM_REG_CTRL)
          ctrl_q <= avs_writedata_i[1:0];
        if (avs_address_i == `SRDM_REG_LIMIT)
          limit_q <= avs_writedata_i[7:0];
      end
    end
  end

  // ============================================================
  // sticky error capture, set wins over clear
  assign err_ev = {pad_nonzero_err_o, eop_abort_o, bad_port_addr_err_o,
    burst_len_err_o, overflow_err_o, sop_spacing_err_o, sob_err_o,
    training_err_o, protocol_err_o, parity_err_o, align_fail_err_o};

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      err_q <= {`SRDM_ERR_BITS{1'b0}};
    else if (avs_write_i & ~avs_waitrequest_o & (avs_address_i == `SRDM_REG_ERR))
      err_q <= (err_q & ~avs_writedata_i[`SRDM_ERR_BITS-1:0]) | err_ev;
    else
      err_q <= err_q | err_ev;
  end

  // ============================================================
  // lane lock and aligner
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1)
    begin : g_lane
      assign lane_d[gi] = lock_cnt_q >= (LOCK_EDGES + gi);
    end
  endgenerate

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_cnt_q <= 8'h0;
      align_cnt_q <= 8'h0;
      lane_locked_o <= {LANES{1'b0}};
      align_fail_err_o <= 1'b0;
      rx_sync_o <= 1'b0;
    end
    else
    begin
      align_fail_err_o <= 1'b0;
      lane_locked_o <= lane_d;
      rx_sync_o <= aligner_locked_o & deskew_q & all_locked & ~out_of_service_o;
      if (ctrl_q[`SRDM_CTRL_UNLOCK])
      begin
        lock_cnt_q <= 8'h0;
        align_cnt_q <= 8'h0;
      end
      else if (ev)
      begin
        if (lock_cnt_q != 8'hff)
          lock_cnt_q <= lock_cnt_q + 8'h1;
        if (all_locked & ~aligner_locked_o)
        begin
          if (align_cnt_q == ALIGN_EDGES[7:0] - 8'h1)
          begin
            align_fail_err_o <= 1'b1;
            align_cnt_q <= 8'h0;
            lock_cnt_q <= 8'h0;
          end
          else
            align_cnt_q <= align_cnt_q + 8'h1;
        end
        else
          align_cnt_q <= 8'h0;
      end
    end
  end

  // ============================================================
  // training, parity service and burst protocol
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      acc_q <= 16'h0;
      last_q <= 16'h0;
      good_q <= 4'h0;
      bad_q <= 4'h0;
      gap_q <= `SRDM_SOP_GAP;
      words_q <= {`SRDM_BURST_WORD_BITS{1'b0}};
      data_seen_q <= 1'b0;
      first_q <= 1'b0;
      deskew_q <= 1'b0;
      aligner_locked_o <= 1'b0;
      training_seen_o <= 1'b0;
      reserved_ctrl_word_seen_o <= 1'b0;
      out_of_service_o <= 1'b1;
      parity_err_o <= 1'b0;
      protocol_err_o <= 1'b0;
      training_err_o <= 1'b0;
      sob_err_o <= 1'b0;
      sop_spacing_err_o <= 1'b0;
      overflow_err_o <= 1'b0;
      burst_len_err_o <= 1'b0;
      bad_port_addr_err_o <= 1'b0;
      eop_abort_o <= 1'b0;
      pad_nonzero_err_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= 16'h0;
      out_sop_o <= 1'b0;
      out_port_o <= 8'h0;
    end
    else
    begin
      parity_err_o <= 1'b0;
      protocol_err_o <= 1'b0;
      training_err_o <= 1'b0;
      sob_err_o <= 1'b0;
      sop_spacing_err_o <= 1'b0;
      overflow_err_o <= 1'b0;
      burst_len_err_o <= 1'b0;
      bad_port_addr_err_o <= 1'b0;
      eop_abort_o <= 1'b0;
      pad_nonzero_err_o <= 1'b0;
      if (out_valid_o & out_ready_i)
        out_valid_o <= 1'b0;
      if (ctrl_q[`SRDM_CTRL_FLUSH])
        out_valid_o <= 1'b0;
      if (ctrl_q[`SRDM_CTRL_UNLOCK])
      begin
        aligner_locked_o <= 1'b0;
        deskew_q <= 1'b0;
        training_seen_o <= 1'b0;
        st_q <= ST_IDLE;
      end
      else if (ev)
      begin
        if (gap_q != `SRDM_SOP_GAP)
          gap_q <= gap_q + 4'h1;
        if (tr_cw)
        begin
          training_seen_o <= 1'b1;
          data_seen_q <= 1'b0;
          acc_q <= 16'h0;
          st_q <= ST_IDLE;
        end
        else if (training_seen_o & tr_dw)
          data_seen_q <= 1'b1;
        else if (training_seen_o)
        begin
          training_seen_o <= 1'b0;
          if (~data_seen_q)
            training_err_o <= 1'b1;
          else if (all_locked)
          begin
            aligner_locked_o <= 1'b1;
            deskew_q <= 1'b1;
          end
        end
        if (~tr_cw & ~tr_dw & c)
        begin
          acc_q <= 16'h0;
          if (mism)
          begin
            parity_err_o <= 1'b1;
            good_q <= 4'h0;
            if (bad_q != 4'hf)
              bad_q <= bad_q + 4'h1;
            if (bad_q + 4'h1 >= limit_q[`SRDM_LIMIT_BAD_LSB+:4])
              out_of_service_o <= 1'b1;
          end
          else
          begin
            bad_q <= 4'h0;
            if (good_q != 4'hf)
              good_q <= good_q + 4'h1;
            if (good_q + 4'h1 >= limit_q[`SRDM_LIMIT_GOOD_LSB+:4])
              out_of_service_o <= 1'b0;
          end
          if (st_q == ST_PAY)
            protocol_err_o <= 1'b1;
          if ((st_q == ST_IDLE) & (eops != `SRDM_EOPS_NONE))
            protocol_err_o <= 1'b1;
          if (st_q == ST_DATA)
          begin
            if ((eops == `SRDM_EOPS_NONE) & (words_q != 0))
              burst_len_err_o <= 1'b1;
            if ((eops == `SRDM_EOPS_ONE) & (last_q[7:0] != 8'h0))
              pad_nonzero_err_o <= 1'b1;
            if (eops == `SRDM_EOPS_ABORT)
              eop_abort_o <= 1'b1;
          end
          if (w[15])
          begin
            st_q <= ST_PAY;
            words_q <= {`SRDM_BURST_WORD_BITS{1'b0}};
            first_q <= w[12];
            out_port_o <= w[11:4];
            if ({24'h0, w[11:4]} >= NUM_PORTS)
              bad_port_addr_err_o <= 1'b1;
            if (w[12])
            begin
              gap_q <= 4'h1;
              if (gap_q < `SRDM_SOP_GAP)
                sop_spacing_err_o <= 1'b1;
            end
          end
          else
          begin
            st_q <= ST_IDLE;
            if (w[12])
              reserved_ctrl_word_seen_o <= 1'b1;
          end
        end
        else if (~tr_cw & ~tr_dw & ~c)
        begin
          acc_q <= acc_q ^ w;
          if (st_q == ST_IDLE)
            sob_err_o <= 1'b1;
          else
          begin
            st_q <= ST_DATA;
            last_q <= w;
            words_q <= words_q + 1'b1;
            first_q <= 1'b0;
            if (~ctrl_q[`SRDM_CTRL_FLUSH])
            begin
              if (out_valid_o & ~out_ready_i)
                overflow_err_o <= 1'b1;
              else
              begin
                out_valid_o <= 1'b1;
                out_data_o <= w;
                out_sop_o <= first_q;
              end
            end
          end
        end
      end
    end
  end

endmodule

// *** srdm_top_checker.sv ***
// checker for the receive monitor, watching top ports only
// assumes one clock domain and binding onto srdm_top
`timescale 1ns/100ps
module srdm_top_checker #(
  parameter LANES = 17
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // register bus
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // status and errors
  input wire aligner_locked_o,
  input wire [LANES-1:0] lane_locked_o,
  input wire rx_sync_o,
  input wire out_of_service_o,
  input wire parity_err_o,
  input wire protocol_err_o,
  input wire sop_spacing_err_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ==========
  // bus handshake steps
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_pulse(e);
    e |=> !e;
  endproperty
  // ==========
  // assertions
  a_bus_answer: assert property (s_take |=> s_answer)
    else $error("bus answer not one cycle");
  a_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o))
    else $error("read data changed without read");
  a_lane_order: assert property (((lane_locked_o >> 1) & ~lane_locked_o) == '0)
    else $error("lane lock out of order");
  a_aligned_lanes: assert property (aligner_locked_o |-> &lane_locked_o)
    else $error("aligned without lane lock");
  a_sync_causes: assert property (rx_sync_o |->
    $past(aligner_locked_o && (&lane_locked_o) && !out_of_service_o))
    else $error("sync without its causes");
  a_parity_pulse: assert property (p_pulse(parity_err_o))
    else $error("parity error too long");
  a_protocol_pulse: assert property (p_pulse(protocol_err_o))
    else $error("protocol error too long");
  a_sop_pulse: assert property (p_pulse(sop_spacing_err_o))
    else $error("sop spacing error too long");
endmodule

bind srdm_top srdm_top_checker #(.LANES(LANES)) chk_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .aligner_locked_o(aligner_locked_o), .lane_locked_o(lane_locked_o), .rx_sync_o(rx_sync_o),
  .out_of_service_o(out_of_service_o), .parity_err_o(parity_err_o),
  .protocol_err_o(protocol_err_o), .sop_spacing_err_o(sop_spacing_err_o));

// *** srdm_link_tx.sv ***
// link transmitter model driving clock and word lanes
// assumes the bench calls send_word; clock stands low between words
`timescale 1ns/100ps
module srdm_link_tx (
  // link pins
  output reg rdclk_o,
  output reg [15:0] rdat_o,
  output reg rctl_o
);
  initial
  begin
    rdclk_o = 1'b0;
    rdat_o = 16'h0000;
    rctl_o = 1'b0;
  end
  // one word, 160 ns, lanes inverted after hold
  task send_word(input logic c, input logic [15:0] w);
  begin
    #1;
    rdat_o = w;
    rctl_o = c;
    #77;
    rdclk_o = 1'b1;
    #80;
    rdclk_o = 1'b0;
    rdat_o = ~w;
    rctl_o = ~c;
    #2;
  end
  endtask
endmodule

// *** srdm_top_test.sv ***
// self-checking bench for the receive monitor
// assumes the link model on the pins and a register bus master here
`timescale 1ns/100ps
`include "srdm_consts.vh"
module srdm_top_test;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic rdy = 1'b1;
  logic [15:0] acc = 16'h0;
  logic [31:0] q;
  wire rdclk, rctl, wt, valid, al_lk, sync, tseen, rsv, oos, osop;
  wire [15:0] rdat, odata;
  wire [31:0] rdata;
  wire [7:0] oport;
  wire [16:0] lanes;
  wire [10:0] ev;
  int miscompares = 0;
  int total_checks = 0;
  int ecnt [11];
  int base [11];
  int acc_n = 0;
  int n0;
  srdm_link_tx link_u (.rdclk_o(rdclk), .rdat_o(rdat), .rctl_o(rctl));
  srdm_top dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rdclk_i(rdclk), .rdat_i(rdat), .rctl_i(rctl),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .out_ready_i(rdy),
    .out_valid_o(valid), .out_data_o(odata), .out_sop_o(osop), .out_port_o(oport),
    .aligner_locked_o(al_lk), .lane_locked_o(lanes), .rx_sync_o(sync),
    .training_seen_o(tseen), .reserved_ctrl_word_seen_o(rsv), .out_of_service_o(oos),
    .align_fail_err_o(ev[0]), .parity_err_o(ev[1]), .protocol_err_o(ev[2]),
    .training_err_o(ev[3]), .sob_err_o(ev[4]), .sop_spacing_err_o(ev[5]),
    .overflow_err_o(ev[6]), .burst_len_err_o(ev[7]), .bad_port_addr_err_o(ev[8]),
    .eop_abort_o(ev[9]), .pad_nonzero_err_o(ev[10]));
  initial
  begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // error pulse and accepted word counters
  always @(posedge clk_sys_i)
  begin
    for (int k = 0; k < 11; k++)
      if (!rst_i && ev[k] === 1'b1)
        ecnt[k] <= ecnt[k] + 1;
    if (valid === 1'b1 && rdy === 1'b1)
      acc_n <= acc_n + 1;
  end
  // ==========
  // tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task print_verdict;
  begin
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk_sys_i);
    while (wt !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus answer", 32'h0, (n == 50));
  end
  endtask
  task word(input logic c, input logic [15:0] w);
  begin
    link_u.send_word(c, w);
    acc = c ? 16'h0 : acc ^ w;
  end
  endtask
  task ctl(input logic t, input logic [1:0] e, input logic s, input logic [7:0] p,
           input logic bad);
    logic [15:0] c;
    logic [15:0] x;
  begin
    c = {t, e, s, p, 4'h0};
    x = acc ^ {c[15:4], 4'hf};
    c[3:0] = x[15:12] ^ x[11:8] ^ x[7:4] ^ x[3:0] ^ {4{bad}};
    word(1'b1, c);
  end
  endtask
  task idle(input logic bad);
  begin
    ctl(1'b0, 2'h0, 1'b0, 8'h00, bad);
  end
  endtask
  task burst(input logic s, input int n, input logic [1:0] e, input logic [15:0] lw);
  begin
    ctl(1'b1, 2'h0, s, 8'h03, 1'b0);
    for (int i = 1; i < n; i++)
      word(1'b0, 16'h1100 + i[15:0]);
    word(1'b0, lw);
    ctl(1'b0, e, 1'b0, 8'h00, 1'b0);
  end
  endtask
  task mark;
  begin
    base = ecnt;
  end
  endtask
  task cnt(input int k, input int n);
  begin
    chk("error count", n, ecnt[k] - base[k]);
  end
  endtask
  // ==========
  // tests
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk("waitrequest", 32'h1, wt);
    chk("out of service", 32'h1, oos);
    bus(1'b0, `SRDM_REG_LIMIT, 32'h0);
    chk("limit", 32'h44, q);
    bus(1'b1, 3'h5, 32'hffff_ffff);
    bus(1'b0, 3'h5, 32'h0);
    chk("unmapped", 32'h0, q);
    mark;
    word(1'b1, `SRDM_TRAIN_CW);
    chk("training seen", 32'h1, tseen);
    idle(1'b0);
    cnt(3, 1);
    word(1'b1, `SRDM_TRAIN_CW);
    repeat (30) word(1'b0, `SRDM_TRAIN_DW);
    chk("lanes", 32'h1ffff, lanes);
    bus(1'b0, `SRDM_REG_LANES, 32'h0);
    chk("lanes reg", 32'h1ffff, q);
    chk("aligned early", 32'h0, al_lk);
    idle(1'b0);
    chk("aligned", 32'h1, al_lk);
    repeat (3) idle(1'b1);
    repeat (3) idle(1'b0);
    chk("oos", 32'h1, oos);
    idle(1'b0);
    chk("oos", 32'h0, oos);
    chk("sync", 32'h1, sync);
    bus(1'b0, `SRDM_REG_STATUS, 32'h0);
    chk("status reg", 32'h7, q);
    mark;
    repeat (3) idle(1'b1);
    chk("oos", 32'h0, oos);
    idle(1'b1);
    chk("oos", 32'h1, oos);
    cnt(1, 4);
    chk("sync", 32'h0, sync);
    n0 = acc_n;
    burst(1'b1, 8, 2'h2, 16'h2222);
    chk("forwarded", n0 + 8, acc_n);
    chk("data", 32'h2222, odata);
    chk("port", 32'h3, oport);
    chk("sop", 32'h0, osop);
    repeat (4) idle(1'b0);
    mark;
    burst(1'b0, 3, 2'h0, 16'h1103);
    cnt(7, 1);
    burst(1'b0, 8, 2'h1, 16'h1108);
    cnt(9, 1);
    burst(1'b0, 7, 2'h3, 16'h1255);
    burst(1'b0, 7, 2'h3, 16'h1200);
    cnt(10, 1);
    word(1'b0, 16'h3333);
    cnt(4, 1);
    ctl(1'b1, 2'h0, 1'b0, 8'h03, 1'b0);
    burst(1'b0, 1, 2'h2, 16'h4444);
    cnt(2, 1);
    burst(1'b1, 2, 2'h2, 16'h1102);
    burst(1'b1, 6, 2'h2, 16'h1106);
    burst(1'b1, 1, 2'h2, 16'h1101);
    cnt(5, 1);
    chk("sop", 32'h1, osop);
    ctl(1'b0, 2'h0, 1'b1, 8'h00, 1'b0);
    chk("reserved", 32'h1, rsv);
    ctl(1'b1, 2'h0, 1'b0, 8'h10, 1'b0);
    word(1'b0, 16'h7777);
    ctl(1'b0, 2'h2, 1'b0, 8'h00, 1'b0);
    cnt(8, 1);
    bus(1'b0, `SRDM_REG_ERR, 32'h0);
    chk("err reg", 32'h7be, q & 32'h7be);
    bus(1'b1, `SRDM_REG_ERR, 32'h7ff);
    bus(1'b0, `SRDM_REG_ERR, 32'h0);
    chk("err clear", 32'h0, q);
    n0 = acc_n;
    bus(1'b1, `SRDM_REG_CTRL, 32'h2);
    burst(1'b0, 8, 2'h2, 16'h5555);
    chk("flushed", n0, acc_n);
    bus(1'b1, `SRDM_REG_CTRL, 32'h0);
    burst(1'b0, 8, 2'h2, 16'h5555);
    chk("after flush", n0 + 8, acc_n);
    mark;
    @(posedge clk_sys_i);
    rdy <= 1'b0;
    burst(1'b0, 2, 2'h2, 16'h6666);
    cnt(6, 1);
    @(posedge clk_sys_i);
    rdy <= 1'b1;
    bus(1'b1, `SRDM_REG_CTRL, 32'h1);
    idle(1'b0);
    chk("lanes unlocked", 32'h0, lanes);
    chk("aligner unlocked", 32'h0, al_lk);
    bus(1'b1, `SRDM_REG_CTRL, 32'h0);
    mark;
    repeat (100) idle(1'b0);
    cnt(0, 1);
    print_verdict;
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    print_verdict;
  end
endmodule
